// >>> verilog/stepper_status_and_current_regs.v
// Status register bank and peak current control of a micro-stepping driver
`timescale 1ns/1ps
`include "stepper_status_consts.vh"

module stepper_status_and_current_regs (
  clk_sys,
  rst,
  cs_n,
  wr_strobe,
  wr_addr,
  wr_data,
  rd_strobe,
  rd_addr,
  rd_data_q,
  thermal_warning_in,
  charge_pump_low_in,
  open_coil_x_in,
  open_coil_y_in,
  ovc_x_pos_top_in,
  ovc_x_pos_bottom_in,
  ovc_x_neg_top_in,
  ovc_x_neg_bottom_in,
  ovc_y_pos_top_in,
  ovc_y_pos_bottom_in,
  ovc_y_neg_top_in,
  ovc_y_neg_bottom_in,
  thermal_shutdown_in,
  microstep_position,
  peak_current_code,
  coil_peak_current,
  current_range,
  range_drop
);
  input wire clk_sys;
  input wire rst;
  input wire cs_n;
  input wire wr_strobe;
  input wire [`ADDR_W-1:0] wr_addr;
  input wire [`REG_W-1:0] wr_data;
  input wire rd_strobe;
  input wire [`ADDR_W-1:0] rd_addr;
  output reg [`REG_W-1:0] rd_data_q;
  input wire thermal_warning_in;
  input wire charge_pump_low_in;
  input wire open_coil_x_in;
  input wire open_coil_y_in;
  input wire ovc_x_pos_top_in;
  input wire ovc_x_pos_bottom_in;
  input wire ovc_x_neg_top_in;
  input wire ovc_x_neg_bottom_in;
  input wire ovc_y_pos_top_in;
  input wire ovc_y_pos_bottom_in;
  input wire ovc_y_neg_top_in;
  input wire ovc_y_neg_bottom_in;
  input wire thermal_shutdown_in;
  input wire [`MICROSTEP_W-1:0] microstep_position;
  output wire [`CUR_CODE_W-1:0] peak_current_code;
  output reg [`CURRENT_MA_W-1:0] coil_peak_current;
  output wire [1:0] current_range;
  output reg range_drop;

  // ---------------------------------------------------------------
  // Peak current control register
  // ---------------------------------------------------------------
  reg [`REG_W-1:0] ctrl_q;
  reg [`REG_W-1:0] ctrl_d;
  reg [`CURRENT_MA_W-1:0] current_ma_d;
  reg range_drop_d;
  wire ctrl_wr;
  wire [`CUR_CODE_W-1:0] new_code;

  assign ctrl_wr = wr_strobe && (wr_addr == `ADDR_CURRENT_CTRL);
  assign new_code = wr_data[`CUR_CODE_MSB:`CUR_CODE_LSB];
  assign peak_current_code = ctrl_q[`CUR_CODE_MSB:`CUR_CODE_LSB];
  assign current_range = ctrl_q[`CUR_RANGE_MSB:`CUR_RANGE_LSB];

  // Writes to status addresses fall through here untouched
  always @* begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = wr_data;
    end
  end

  // Typical amplitude in mA for each code, rising with the code
  always @* begin
    case (ctrl_d[`CUR_CODE_MSB:`CUR_CODE_LSB])
      5'h00: current_ma_d = 11'd33;
      5'h01: current_ma_d = 11'd64;
      5'h02: current_ma_d = 11'd95;
      5'h03: current_ma_d = 11'd104;
      5'h04: current_ma_d = 11'd115;
      5'h05: current_ma_d = 11'd126;
      5'h06: current_ma_d = 11'd138;
      5'h07: current_ma_d = 11'd153;
      5'h08: current_ma_d = 11'd166;
      5'h09: current_ma_d = 11'd190;
      5'h0a: current_ma_d = 11'd205;
      5'h0b: current_ma_d = 11'd230;
      5'h0c: current_ma_d = 11'd250;
      5'h0d: current_ma_d = 11'd275;
      5'h0e: current_ma_d = 11'd300;
      5'h0f: current_ma_d = 11'd325;
      5'h10: current_ma_d = 11'd365;
      5'h11: current_ma_d = 11'd400;
      5'h12: current_ma_d = 11'd440;
      5'h13: current_ma_d = 11'd485;
      5'h14: current_ma_d = 11'd530;
      5'h15: current_ma_d = 11'd585;
      5'h16: current_ma_d = 11'd630;
      5'h17: current_ma_d = 11'd750;
      5'h18: current_ma_d = 11'd825;
      5'h19: current_ma_d = 11'd895;
      5'h1a: current_ma_d = 11'd975;
      5'h1b: current_ma_d = 11'd1065;
      5'h1c: current_ma_d = 11'd1155;
      5'h1d: current_ma_d = 11'd1245;
      5'h1e: current_ma_d = 11'd1365;
      5'h1f: current_ma_d = 11'd1480;
      default: current_ma_d = `CURRENT_MA_RESET;
    endcase
  end

  // One-cycle warning when a write moves the current into a lower range
  always @* begin
    range_drop_d = 1'b0;
    if (ctrl_wr && (new_code[`CUR_RANGE_MSB:`CUR_RANGE_LSB] < current_range)) begin
      range_drop_d = 1'b1;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
      coil_peak_current <= `CURRENT_MA_RESET;
      range_drop <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      coil_peak_current <= current_ma_d;
      range_drop <= range_drop_d;
    end
  end

  // ---------------------------------------------------------------
  // Sticky overcurrent and shutdown flags
  // ---------------------------------------------------------------
  reg [3:0] ovc_x_q;
  reg [3:0] ovc_y_q;
  reg tsd_q;
  reg [3:0] ovc_x_d;
  reg [3:0] ovc_y_d;
  reg tsd_d;
  wire [3:0] ovc_x_det;
  wire [3:0] ovc_y_det;
  wire clr_x;
  wire clr_y;
  wire [3:0] shown_x;
  wire [3:0] shown_y;
  wire shown_tsd;

  // Order: positive top, positive bottom, negative top, negative bottom
  assign ovc_x_det = {ovc_x_pos_top_in, ovc_x_pos_bottom_in, ovc_x_neg_top_in,
                      ovc_x_neg_bottom_in};
  assign ovc_y_det = {ovc_y_pos_top_in, ovc_y_pos_bottom_in, ovc_y_neg_top_in,
                      ovc_y_neg_bottom_in};
  assign clr_x = rd_strobe && (rd_addr == `ADDR_PHASE_X_OVC);
  assign clr_y = rd_strobe && (rd_addr == `ADDR_PHASE_Y_OVC_THERM);

  // A fault in the clearing cycle survives the clear
  // Only flags already in the read snapshot are cleared, so none is lost unseen
  always @* begin
    ovc_x_d = (ovc_x_q & ~(shown_x & {4{clr_x}})) | ovc_x_det;
    ovc_y_d = (ovc_y_q & ~(shown_y & {4{clr_y}})) | ovc_y_det;
    tsd_d = (tsd_q & ~(shown_tsd & clr_y)) | thermal_shutdown_in;
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovc_x_q <= 4'h0;
      ovc_y_q <= 4'h0;
      tsd_q <= 1'b0;
    end else begin
      ovc_x_q <= ovc_x_d;
      ovc_y_q <= ovc_y_d;
      tsd_q <= tsd_d;
    end
  end

  // ---------------------------------------------------------------
  // Status register contents
  // ---------------------------------------------------------------
  reg [6:0] live_fault_bits;
  reg [6:0] phase_x_bits;
  reg [6:0] phase_y_bits;
  wire refresh;
  wire [`REG_W-1:0] live_fault_status;
  wire [`REG_W-1:0] phase_x_overcurrent_status;
  wire [`REG_W-1:0] phase_y_overcurrent_thermal_status;
  wire [`REG_W-1:0] step_position_status;

  // Snapshots follow the sources only while the master is deselected
  assign refresh = cs_n;

  // Flags the master sees when it reads a latched register
  assign shown_x = phase_x_overcurrent_status[`BIT_OVC_POS_TOP:`BIT_OVC_NEG_BOTTOM];
  assign shown_y = phase_y_overcurrent_thermal_status[`BIT_OVC_POS_TOP:`BIT_OVC_NEG_BOTTOM];
  assign shown_tsd = phase_y_overcurrent_thermal_status[`BIT_THERMAL_SHUTDOWN];

  always @* begin
    live_fault_bits = 7'h00;
    live_fault_bits[`BIT_THERMAL_WARNING] = thermal_warning_in;
    live_fault_bits[`BIT_CHARGE_PUMP_FAIL] = charge_pump_low_in;
    live_fault_bits[`BIT_OPEN_COIL_X] = open_coil_x_in;
    live_fault_bits[`BIT_OPEN_COIL_Y] = open_coil_y_in;
  end

  always @* begin
    phase_x_bits = 7'h00;
    phase_x_bits[`BIT_OVC_POS_TOP] = ovc_x_q[3];
    phase_x_bits[`BIT_OVC_POS_BOTTOM] = ovc_x_q[2];
    phase_x_bits[`BIT_OVC_NEG_TOP] = ovc_x_q[1];
    phase_x_bits[`BIT_OVC_NEG_BOTTOM] = ovc_x_q[0];
  end

  always @* begin
    phase_y_bits = 7'h00;
    phase_y_bits[`BIT_OVC_POS_TOP] = ovc_y_q[3];
    phase_y_bits[`BIT_OVC_POS_BOTTOM] = ovc_y_q[2];
    phase_y_bits[`BIT_OVC_NEG_TOP] = ovc_y_q[1];
    phase_y_bits[`BIT_OVC_NEG_BOTTOM] = ovc_y_q[0];
    phase_y_bits[`BIT_THERMAL_SHUTDOWN] = tsd_q;
  end

  status_parity_reg u_live_fault (
    .clk_sys(clk_sys),
    .rst(rst),
    .refresh(refresh),
    .data_in(live_fault_bits),
    .reg_q(live_fault_status)
  );

  status_parity_reg u_phase_x (
    .clk_sys(clk_sys),
    .rst(rst),
    .refresh(refresh),
    .data_in(phase_x_bits),
    .reg_q(phase_x_overcurrent_status)
  );

  status_parity_reg u_phase_y (
    .clk_sys(clk_sys),
    .rst(rst),
    .refresh(refresh),
    .data_in(phase_y_bits),
    .reg_q(phase_y_overcurrent_thermal_status)
  );

  status_parity_reg u_step_position (
    .clk_sys(clk_sys),
    .rst(rst),
    .refresh(refresh),
    .data_in(microstep_position),
    .reg_q(step_position_status)
  );

  // ---------------------------------------------------------------
  // Read-out
  // ---------------------------------------------------------------
  reg [`REG_W-1:0] rd_data_d;

  always @* begin
    rd_data_d = rd_data_q;
    if (rd_strobe) begin
      case (rd_addr)
        `ADDR_CURRENT_CTRL: rd_data_d = ctrl_q;
        `ADDR_LIVE_FAULT: rd_data_d = live_fault_status;
        `ADDR_PHASE_X_OVC: rd_data_d = phase_x_overcurrent_status;
        `ADDR_PHASE_Y_OVC_THERM: rd_data_d = phase_y_overcurrent_thermal_status;
        `ADDR_STEP_POSITION: rd_data_d = step_position_status;
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_q <= `STATUS_RESET;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end
endmodule // stepper_status_and_current_regs

// >>> verilog/stepper_status_consts.vh
// Constants for the stepper status and current register bank
`ifndef STEPPER_STATUS_CONSTS_VH
`define STEPPER_STATUS_CONSTS_VH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define ADDR_W 5
`define ADDR_CURRENT_CTRL 5'h01
`define ADDR_LIVE_FAULT 5'h04
`define ADDR_PHASE_X_OVC 5'h05
`define ADDR_PHASE_Y_OVC_THERM 5'h06
`define ADDR_STEP_POSITION 5'h07

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_PARITY 7
`define BIT_THERMAL_WARNING 6
`define BIT_CHARGE_PUMP_FAIL 5
`define BIT_OPEN_COIL_X 3
`define BIT_OPEN_COIL_Y 2
`define BIT_OVC_POS_TOP 6
`define BIT_OVC_POS_BOTTOM 5
`define BIT_OVC_NEG_TOP 4
`define BIT_OVC_NEG_BOTTOM 3
`define BIT_THERMAL_SHUTDOWN 2
`define CUR_CODE_MSB 4
`define CUR_CODE_LSB 0
`define CUR_RANGE_MSB 4
`define CUR_RANGE_LSB 3

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define REG_W 8
`define CUR_CODE_W 5
`define CURRENT_MA_W 11
`define MICROSTEP_W 7
`define STATUS_RESET 8'h00
`define CTRL_RESET 8'h00
`define MICROSTEP_RESET 7'h00
`define CURRENT_MA_RESET 11'h021

`endif

// >>> verilog/status_parity_reg.v
// One status register: snapshot of seven data bits plus even parity bit
`timescale 1ns/1ps
`include "stepper_status_consts.vh"

module status_parity_reg (
  clk_sys,
  rst,
  refresh,
  data_in,
  reg_q
);
  input wire clk_sys;
  input wire rst;
  input wire refresh;
  input wire [6:0] data_in;
  output reg [7:0] reg_q;

  wire [7:0] reg_d;

  // Bit 7 makes the count of ones over all eight bits even
  assign reg_d = refresh ? {^data_in, data_in} : reg_q;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_q <= `STATUS_RESET;
    end else begin
      reg_q <= reg_d;
    end
  end
endmodule // status_parity_reg

// >>> testbench/stepper_status_and_current_regs_sva.sv
// Checker for the status register bank and peak current control
`timescale 1ns/1ps
`include "stepper_status_consts.vh"

module stepper_status_checker (
  input wire clk_sys,
  input wire rst,
  input wire cs_n,
  input wire wr_strobe,
  input wire [`ADDR_W-1:0] wr_addr,
  input wire [`REG_W-1:0] wr_data,
  input wire rd_strobe,
  input wire [`ADDR_W-1:0] rd_addr,
  input wire [`REG_W-1:0] rd_data_q,
  input wire [`MICROSTEP_W-1:0] microstep_position,
  input wire [`CUR_CODE_W-1:0] peak_current_code,
  input wire [`CURRENT_MA_W-1:0] coil_peak_current,
  input wire [1:0] current_range,
  input wire range_drop
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_code_follows_write: assert property (wr_strobe && wr_addr == `ADDR_CURRENT_CTRL |=>
    peak_current_code == $past(wr_data[4:0])) else $error("code not taken from write");
  a_current_ends: assert property ((peak_current_code == 5'h1f) == (coil_peak_current == 11'h5c8)
    && (peak_current_code == 5'h00) == (coil_peak_current == 11'h021)) else $error("bad end amplitude");
  a_write_ignored: assert property (wr_strobe && wr_addr != `ADDR_CURRENT_CTRL |=>
    $stable(peak_current_code)) else $error("ignored write changed code");
  a_read_parity: assert property (rd_strobe && rd_addr >= `ADDR_LIVE_FAULT && rd_addr <= 5'h07 |=>
    ^rd_data_q == 1'b0) else $error("status parity odd");
  a_read_holds: assert property (!rd_strobe |=> $stable(rd_data_q))
    else $error("read data moved without strobe");
  a_step_position: assert property (rd_strobe && rd_addr == `ADDR_STEP_POSITION && $past(cs_n)
    |=> $past(rst, 2) || rd_data_q[6:0] == $past(microstep_position, 2))
    else $error("step position mismatch");
  a_unused_zero: assert property (rd_strobe && rd_addr == `ADDR_LIVE_FAULT |=>
    rd_data_q[4] == 1'b0 && rd_data_q[1:0] == 2'h0) else $error("unused live bits set");
  a_range_drop: assert property (range_drop |-> $past(wr_strobe) &&
    current_range < $past(current_range)) else $error("range drop without lowering");
  a_drop_fires: assert property (wr_strobe && wr_addr == `ADDR_CURRENT_CTRL &&
    wr_data[4:3] < current_range |=> range_drop) else $error("range drop missed");
endmodule // stepper_status_checker

// >>> testbench/mcu_model.sv
// Microcontroller side: chip select and register read and write transfers
`timescale 1ns/1ps
`include "stepper_status_consts.vh"

module mcu_model (
  input wire clk_sys,
  input wire [`REG_W-1:0] rd_data_q,
  output reg cs_n,
  output reg wr_strobe,
  output reg [`ADDR_W-1:0] wr_addr,
  output reg [`REG_W-1:0] wr_data,
  output reg rd_strobe,
  output reg [`ADDR_W-1:0] rd_addr
);
  initial begin
    cs_n = 1'b1;
    wr_strobe = 1'b0;
    wr_addr = 5'h00;
    wr_data = 8'h00;
    rd_strobe = 1'b0;
    rd_addr = 5'h00;
  end
  // Complete write transfer, one strobe cycle
  task write_reg(input [4:0] a, input [7:0] d);
    @(posedge clk_sys);
    #2 wr_addr = a;
    wr_data = d;
    wr_strobe = 1'b1;
    @(posedge clk_sys);
    #2 wr_strobe = 1'b0;
    wr_data = ~d;
  endtask
  // Read-out event; data is taken one edge after the strobe
  task read_reg(input [4:0] a, output [7:0] d);
    @(posedge clk_sys);
    #2 rd_addr = a;
    rd_strobe = 1'b1;
    @(posedge clk_sys);
    #2 rd_strobe = 1'b0;
    d = rd_data_q;
  endtask
  // Chip select level, called just after a clock edge
  task set_select(input s);
    cs_n = s;
  endtask
endmodule // mcu_model

// >>> testbench/stepper_status_and_current_regs_test.sv
// Self-checking bench for the status register bank and peak current control
`timescale 1ns/1ps
`include "stepper_status_consts.vh"

module stepper_status_and_current_regs_test;
  reg clk_sys, rst;
  reg [12:0] flt;
  reg [6:0] step;
  wire cs_n, wr_strobe, rd_strobe, range_drop;
  wire [4:0] wr_addr, rd_addr, peak_current_code;
  wire [7:0] wr_data, rd_data_q;
  wire [10:0] coil_peak_current;
  wire [1:0] current_range;
  reg [7:0] d;
  reg [4:0] codes [0:4];
  reg [10:0] amps [0:4];
  integer n_errors = 0, total_checks = 0, i;

  stepper_status_and_current_regs stepper_status_and_current_regs_inst (
    .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
    .thermal_warning_in(flt[12]), .charge_pump_low_in(flt[11]), .open_coil_x_in(flt[10]),
    .open_coil_y_in(flt[9]), .ovc_x_pos_top_in(flt[8]), .ovc_x_pos_bottom_in(flt[7]),
    .ovc_x_neg_top_in(flt[6]), .ovc_x_neg_bottom_in(flt[5]), .ovc_y_pos_top_in(flt[4]),
    .ovc_y_pos_bottom_in(flt[3]), .ovc_y_neg_top_in(flt[2]), .ovc_y_neg_bottom_in(flt[1]),
    .thermal_shutdown_in(flt[0]), .microstep_position(step),
    .peak_current_code(peak_current_code), .coil_peak_current(coil_peak_current),
    .current_range(current_range), .range_drop(range_drop));
  mcu_model mcu_model_inst (.clk_sys(clk_sys), .rd_data_q(rd_data_q), .cs_n(cs_n),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .rd_strobe(rd_strobe),
    .rd_addr(rd_addr));

  task check(input [79:0] what, input [10:0] seen, input [10:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      $display("unexpected %0s expected %h seen %h", what, exp, seen);
      n_errors = n_errors + 1;
    end
  endtask
  // Pulse fault inputs for one cycle, then let the sticky path settle
  task pulse(input [12:0] f);
    @(posedge clk_sys);
    #2 flt = f;
    @(posedge clk_sys);
    #2 flt = 13'h0000;
    repeat (3) @(posedge clk_sys);
  endtask
  task rd_chk(input [4:0] a, input [7:0] exp);
    mcu_model_inst.read_reg(a, d);
    check("status", {3'h0, d}, {3'h0, exp});
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #(25 * 3000);
    n_errors = n_errors + 1;
    end_sim;
  end
  initial begin
    rst = 1'b1;
    flt = 13'h0000;
    step = 7'h00;
    codes[0] = 5'h00; codes[1] = 5'h08; codes[2] = 5'h10; codes[3] = 5'h18; codes[4] = 5'h1f;
    amps[0] = 11'h021; amps[1] = 11'h0a6; amps[2] = 11'h16d; amps[3] = 11'h339; amps[4] = 11'h5c8;
    repeat (4) @(posedge clk_sys);
    #2 rst = 1'b0;
    for (i = 4; i < 8; i = i + 1) rd_chk(i[4:0], 8'h00);
    $display("reset values done");
    for (i = 0; i < 5; i = i + 1) begin
      mcu_model_inst.write_reg(`ADDR_CURRENT_CTRL, {3'h5, codes[i]});
      check("amplitude", coil_peak_current, amps[i]);
      check("drop", {10'h000, range_drop}, 11'h000);
      rd_chk(`ADDR_CURRENT_CTRL, {3'h5, codes[i]});
    end
    // Lowering across ranges is done in steps of one range only
    mcu_model_inst.write_reg(`ADDR_CURRENT_CTRL, 8'h10);
    check("drop", {10'h000, range_drop}, 11'h001);
    mcu_model_inst.write_reg(`ADDR_CURRENT_CTRL, 8'h08);
    check("drop", {10'h000, range_drop}, 11'h001);
    check("range", {9'h000, current_range}, 11'h001);
    for (i = 4; i < 8; i = i + 1) mcu_model_inst.write_reg(i[4:0], 8'hff);
    check("code", {6'h00, peak_current_code}, 11'h008);
    rd_chk(`ADDR_PHASE_X_OVC, 8'h00);
    $display("current control done");
    flt = 13'h1400;
    rd_chk(`ADDR_LIVE_FAULT, 8'h48);
    flt = 13'h0a00;
    repeat (2) @(posedge clk_sys);
    rd_chk(`ADDR_LIVE_FAULT, 8'h24);
    flt = 13'h0000;
    repeat (2) @(posedge clk_sys);
    rd_chk(`ADDR_LIVE_FAULT, 8'h00);
    $display("live faults done");
    pulse(13'h0100);
    rd_chk(`ADDR_PHASE_X_OVC, 8'hc0);
    rd_chk(`ADDR_PHASE_X_OVC, 8'h00);
    repeat (3) @(posedge clk_sys);
    rd_chk(`ADDR_PHASE_X_OVC, 8'h00);
    pulse(13'h00a0);
    rd_chk(`ADDR_PHASE_X_OVC, 8'h28);
    pulse(13'h0005);
    rd_chk(`ADDR_PHASE_Y_OVC_THERM, 8'h14);
    pulse(13'h001a);
    rd_chk(`ADDR_PHASE_Y_OVC_THERM, 8'he8);
    $display("latched faults done");
    step = 7'h55;
    repeat (2) @(posedge clk_sys);
    rd_chk(`ADDR_STEP_POSITION, 8'h55);
    step = 7'h01;
    repeat (2) @(posedge clk_sys);
    rd_chk(`ADDR_STEP_POSITION, 8'h81);
    mcu_model_inst.set_select(1'b0);
    step = 7'h2a;
    repeat (3) @(posedge clk_sys);
    rd_chk(`ADDR_STEP_POSITION, 8'h81);
    mcu_model_inst.set_select(1'b1);
    repeat (2) @(posedge clk_sys);
    rd_chk(`ADDR_STEP_POSITION, 8'haa);
    $display("step position done");
    end_sim;
  end
endmodule // stepper_status_and_current_regs_test

bind stepper_status_and_current_regs stepper_status_checker stepper_status_checker_inst (
  .clk_sys, .rst, .cs_n, .wr_strobe, .wr_addr, .wr_data, .rd_strobe, .rd_addr, .rd_data_q,
  .microstep_position, .peak_current_code, .coil_peak_current, .current_range, .range_drop);
